// [verilog/drc_ctrl.sv]
/*
 Conversion control of a dual simultaneous-sampling converter: span pins,
 channel-pair select, track/hold and busy sequencing, power-down, results.
 Assumes pins are asynchronous to clk_sys and a plain register port master.
*/
`timescale 1ns/1ps
module drc_ctrl #(
   parameter int unsigned RES = drc_pkg::RES_BITS_DEF
) (
   input  wire logic                             clk_sys,
   input  wire logic                             rstn,
   input  wire logic                             convert_start_n,
   input  wire logic                             span_sel_lo,
   input  wire logic                             span_sel_hi,
   input  wire logic                             chan_addr,
   input  wire logic signed [drc_pkg::VIN_W-1:0] conv_a_input_one,
   input  wire logic signed [drc_pkg::VIN_W-1:0] conv_a_input_two,
   input  wire logic signed [drc_pkg::VIN_W-1:0] conv_b_input_one,
   input  wire logic signed [drc_pkg::VIN_W-1:0] conv_b_input_two,
   input  wire logic        [3:0]                reg_addr,
   input  wire logic        [31:0]               reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   output logic             [31:0]               reg_rdata,
   output logic                                  busy,
   output logic                                  tracking,
   output logic                                  powered_down,
   output logic                                  span_fault,
   output logic             [RES-1:0]            result_a,
   output logic             [RES-1:0]            result_b
);

   localparam int unsigned AW = drc_pkg::VIN_W;
   localparam int unsigned TW = drc_pkg::TRK_CNT_W;

   logic [3:0]        ctl_s;
   logic [4*AW-1:0]   ana_s;
   logic              start_s, addr_s;
   logic [1:0]        span_s;
   logic signed [AW-1:0] a1_s, a2_s, b1_s, b2_s;

   drc_sync #(.WIDTH(4)) u_sync_ctl (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .din     ({convert_start_n, chan_addr, span_sel_hi, span_sel_lo}),
      .dout    (ctl_s)
   );

   drc_sync #(.WIDTH(4*AW)) u_sync_ana (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .din     ({conv_a_input_one, conv_a_input_two, conv_b_input_one, conv_b_input_two}),
      .dout    (ana_s)
   );

   always_comb
   begin
      start_s = ctl_s[3];
      addr_s  = ctl_s[2];
      span_s  = ctl_s[1:0];
      a1_s    = $signed(ana_s[4*AW-1:3*AW]);
      a2_s    = $signed(ana_s[3*AW-1:2*AW]);
      b1_s    = $signed(ana_s[2*AW-1:AW]);
      b2_s    = $signed(ana_s[AW-1:0]);
   end

   drc_pkg::drc_state_e state_r, state_nxt;
   logic                 start_q_r, start_q_nxt;
   logic                 busy_r, busy_nxt;
   logic                 busy_q_r, busy_q_nxt;
   logic                 trk_r, trk_nxt;
   logic                 pdn_r, pdn_nxt;
   logic                 chan_r, chan_nxt;
   logic [1:0]           span_r, span_nxt;
   logic                 fault_r, fault_nxt;
   logic                 acq_r, acq_nxt;
   logic [TW-1:0]        tcnt_r, tcnt_nxt;
   logic signed [AW-1:0] samp_a_r, samp_a_nxt;
   logic signed [AW-1:0] samp_b_r, samp_b_nxt;
   logic [drc_pkg::SPAN_W-1:0] cspan_r, cspan_nxt;
   logic signed [AW-1:0] clow_r, clow_nxt;
   logic [RES-1:0]       res_a_r, res_a_nxt;
   logic [RES-1:0]       res_b_r, res_b_nxt;
   logic [31:0]          rdata_r, rdata_nxt;
   logic                 start_fall, start_rise, sar_go, done_a, done_b;
   logic                 clr_fault, clr_acq;
   logic [RES-1:0]       code_a, code_b;

   // Conversion starts one cycle after hold, from the frozen samples
   drc_sar #(.RES(RES)) u_sar_a (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .start   (sar_go),
      .vin     (samp_a_r),
      .low     (clow_r),
      .span    (cspan_r),
      .done    (done_a),
      .code    (code_a)
   );

   drc_sar #(.RES(RES)) u_sar_b (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .start   (sar_go),
      .vin     (samp_b_r),
      .low     (clow_r),
      .span    (cspan_r),
      .done    (done_b),
      .code    (code_b)
   );

   always_comb
   begin
      start_fall  = start_q_r & ~start_s;
      start_rise  = ~start_q_r & start_s;
      sar_go      = busy_r & ~busy_q_r;
      clr_fault   = reg_wr && reg_addr == drc_pkg::REG_CTRL && reg_wdata[drc_pkg::CT_FAULT_CLR];
      clr_acq     = reg_wr && reg_addr == drc_pkg::REG_CTRL && reg_wdata[drc_pkg::CT_ACQ_CLR];
      state_nxt   = state_r;
      start_q_nxt = start_s;
      busy_nxt    = busy_r;
      busy_q_nxt  = busy_r;
      trk_nxt     = trk_r;
      pdn_nxt     = pdn_r;
      chan_nxt    = chan_r;
      span_nxt    = span_r;
      fault_nxt   = fault_r & ~clr_fault;
      acq_nxt     = acq_r & ~clr_acq;
      tcnt_nxt    = tcnt_r;
      samp_a_nxt  = samp_a_r;
      samp_b_nxt  = samp_b_r;
      cspan_nxt   = cspan_r;
      clow_nxt    = clow_r;
      res_a_nxt   = res_a_r;
      res_b_nxt   = res_b_r;

      // Reserved code keeps old span; set wins over clear
      if (span_s == drc_pkg::SPAN_RSVD)
         fault_nxt = 1'b1;
      else
         span_nxt = span_s;

      // Latch channel pin on busy rise, for the next conversion
      if (sar_go)
         chan_nxt = addr_s;

      if (trk_r && tcnt_r != '1)
         tcnt_nxt = tcnt_r + TW'(1);

      case (state_r)
         drc_pkg::DRC_TRACK:
         begin
            // Hold both inputs at the same edge
            if (start_fall)
            begin
               state_nxt  = drc_pkg::DRC_CONV;
               busy_nxt   = 1'b1;
               trk_nxt    = 1'b0;
               // Channel pair from the captured select
               samp_a_nxt = chan_r ? a2_s : a1_s;
               samp_b_nxt = chan_r ? b2_s : b1_s;
               // Short acquisition is only flagged, conversion still runs
               if (tcnt_r < TW'(drc_pkg::ACQ_CYC))
                  acq_nxt = 1'b1;
               case (span_r)
                  drc_pkg::SPAN_BIP5:
                  begin
                     cspan_nxt = drc_pkg::SPAN_UV_10V;
                     clow_nxt  = drc_pkg::LOW_UV_M5;
                  end
                  drc_pkg::SPAN_UNI10:
                  begin
                     cspan_nxt = drc_pkg::SPAN_UV_10V;
                     clow_nxt  = drc_pkg::LOW_UV_0;
                  end
                  default:
                  begin
                     cspan_nxt = drc_pkg::SPAN_UV_20V;
                     clow_nxt  = drc_pkg::LOW_UV_M10;
                  end
               endcase
            end
         end
         drc_pkg::DRC_CONV:
         begin
            // Busy ends when both converters finish
            if (done_a && done_b)
            begin
               busy_nxt  = 1'b0;
               // Back to track on busy fall
               trk_nxt   = 1'b1;
               tcnt_nxt  = '0;
               res_a_nxt = code_a;
               res_b_nxt = code_b;
               // Start still low: power down after this conversion
               if (!start_s)
               begin
                  state_nxt = drc_pkg::DRC_PDOWN;
                  pdn_nxt   = 1'b1;
               end
               else
                  state_nxt = drc_pkg::DRC_TRACK;
            end
         end
         drc_pkg::DRC_PDOWN:
         begin
            // Results stay readable; only a start rise wakes the core
            if (start_rise)
            begin
               state_nxt = drc_pkg::DRC_TRACK;
               pdn_nxt   = 1'b0;
            end
         end
         default:
            state_nxt = drc_pkg::DRC_TRACK;
      endcase

      rdata_nxt = 32'h00000000;
      if (reg_rd)
      begin
         case (reg_addr)
            drc_pkg::REG_STATUS:
            begin
               rdata_nxt[drc_pkg::ST_BUSY_BIT]  = busy_r;
               rdata_nxt[drc_pkg::ST_TRK_BIT]   = trk_r;
               rdata_nxt[drc_pkg::ST_PDN_BIT]   = pdn_r;
               rdata_nxt[drc_pkg::ST_CHAN_BIT]  = chan_r;
               rdata_nxt[drc_pkg::ST_SPAN_LSB +: 2] = span_r;
               rdata_nxt[drc_pkg::ST_FAULT_BIT] = fault_r;
               rdata_nxt[drc_pkg::ST_ACQ_BIT]   = acq_r;
            end
            drc_pkg::REG_RESULT_A: rdata_nxt[RES-1:0] = res_a_r;
            drc_pkg::REG_RESULT_B: rdata_nxt[RES-1:0] = res_b_r;
            default:               rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r   <= drc_pkg::DRC_TRACK;
         // Same as synced reset level: no false start edge after reset
         start_q_r <= 1'b0;
         busy_r    <= 1'b0;
         busy_q_r  <= 1'b0;
         trk_r     <= 1'b1;
         pdn_r     <= 1'b0;
         chan_r    <= 1'b0;
         span_r    <= drc_pkg::SPAN_RST;
         fault_r   <= 1'b0;
         acq_r     <= 1'b0;
         tcnt_r    <= '0;
         samp_a_r  <= '0;
         samp_b_r  <= '0;
         cspan_r   <= drc_pkg::SPAN_UV_20V;
         clow_r    <= drc_pkg::LOW_UV_M10;
         res_a_r   <= '0;
         res_b_r   <= '0;
         rdata_r   <= 32'h00000000;
      end
      else
      begin
         state_r   <= state_nxt;
         start_q_r <= start_q_nxt;
         busy_r    <= busy_nxt;
         busy_q_r  <= busy_q_nxt;
         trk_r     <= trk_nxt;
         pdn_r     <= pdn_nxt;
         chan_r    <= chan_nxt;
         span_r    <= span_nxt;
         fault_r   <= fault_nxt;
         acq_r     <= acq_nxt;
         tcnt_r    <= tcnt_nxt;
         samp_a_r  <= samp_a_nxt;
         samp_b_r  <= samp_b_nxt;
         cspan_r   <= cspan_nxt;
         clow_r    <= clow_nxt;
         res_a_r   <= res_a_nxt;
         res_b_r   <= res_b_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   assign reg_rdata    = rdata_r;
   assign busy         = busy_r;
   assign tracking     = trk_r;
   assign powered_down = pdn_r;
   assign span_fault   = fault_r;
   assign result_a     = res_a_r;
   assign result_b     = res_b_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   localparam int BUSY_MAX = RES + 3;
   logic seen_busy_r;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         seen_busy_r <= 1'b0;
      else if (busy_r)
         seen_busy_r <= 1'b1;
   end

   sequence s_hold;
      state_r == drc_pkg::DRC_TRACK && start_fall;
   endsequence
   sequence s_conv_end;
      busy_r ##1 !busy_r;
   endsequence

   a_span_decode: assert property (
      span_s != drc_pkg::SPAN_RSVD |=> span_r == $past(span_s))
      else $error("Span register did not follow legal pins");
   a_span_shared: assert property (
      s_hold |=> cspan_r == (($past(span_r) == drc_pkg::SPAN_BIP10) ? drc_pkg::SPAN_UV_20V : drc_pkg::SPAN_UV_10V))
      else $error("Conversion span does not match selected range");
   a_chan_capture: assert property (
      sar_go |=> chan_r == $past(addr_s))
      else $error("Channel select not captured on busy rise");
   a_chan_route: assert property (
      s_hold |=> samp_a_r == ($past(chan_r) ? $past(a2_s) : $past(a1_s)))
      else $error("Wrong input routed to converter A");
   a_chan_default: assert property (
      !seen_busy_r |-> chan_r == 1'b0)
      else $error("Input one not selected before first capture");
   a_track_resume: assert property (
      s_conv_end |-> trk_r && !$past(trk_r))
      else $error("Tracking did not start at busy fall");
   a_hold_start: assert property (
      s_hold |=> !trk_r && busy_r)
      else $error("Hold or busy missing after start edge");
   a_busy_span: assert property (
      $rose(busy_r) |-> busy_r [*2] ##[1:BUSY_MAX] !busy_r)
      else $error("Busy width out of bounds");
   a_pdown_entry: assert property (
      s_conv_end |-> pdn_r == !$past(start_s, 1))
      else $error("Power-down choice wrong at conversion end");
   a_span_keep: assert property (
      span_s == drc_pkg::SPAN_RSVD |=> fault_r && $stable(span_r))
      else $error("Reserved span not flagged or span changed");

endmodule

// [verilog/drc_pkg.sv]
/*
 Constants for the dual converter range and channel control block.
 Assumes a 10 MHz system clock; shared by the control core and its leaves.
*/
package drc_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned T_ACQ_NS      = 140;
   // Least tracking time rounds up to whole cycles
   localparam int unsigned ACQ_CYC       = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TRK_CNT_W     = 4;

   // Result width, larger variant; the smaller one uses 12
   localparam int unsigned RES_BITS_DEF  = 14;
   localparam int unsigned VIN_W         = 26;
   localparam int unsigned SPAN_W        = 25;

   // Span encodings {span_sel_hi, span_sel_lo}
   localparam logic [1:0] SPAN_BIP10     = 2'h0;
   localparam logic [1:0] SPAN_BIP5      = 2'h1;
   localparam logic [1:0] SPAN_UNI10     = 2'h2;
   localparam logic [1:0] SPAN_RSVD      = 2'h3;
   localparam logic [1:0] SPAN_RST       = SPAN_BIP10;

   // Span widths and low ends in microvolts
   localparam logic [SPAN_W-1:0]        SPAN_UV_20V = 25'h1312D00;
   localparam logic [SPAN_W-1:0]        SPAN_UV_10V = 25'h0989680;
   localparam logic signed [VIN_W-1:0]  LOW_UV_M10  = -26'sh0989680;
   localparam logic signed [VIN_W-1:0]  LOW_UV_M5   = -26'sh04C4B40;
   localparam logic signed [VIN_W-1:0]  LOW_UV_0    = 26'sh0000000;

   // Register map (byte addresses)
   localparam logic [3:0] REG_STATUS    = 4'h0;
   localparam logic [3:0] REG_RESULT_A  = 4'h4;
   localparam logic [3:0] REG_RESULT_B  = 4'h8;
   localparam logic [3:0] REG_CTRL      = 4'hC;

   // Status fields
   localparam int unsigned ST_BUSY_BIT  = 0;
   localparam int unsigned ST_TRK_BIT   = 1;
   localparam int unsigned ST_PDN_BIT   = 2;
   localparam int unsigned ST_CHAN_BIT  = 3;
   localparam int unsigned ST_SPAN_LSB  = 4;
   localparam int unsigned ST_FAULT_BIT = 6;
   localparam int unsigned ST_ACQ_BIT   = 7;
   // Control fields, write one to clear
   localparam int unsigned CT_FAULT_CLR = 0;
   localparam int unsigned CT_ACQ_CLR   = 1;

   typedef enum logic [1:0] {
      DRC_TRACK = 2'b00,
      DRC_CONV  = 2'b01,
      DRC_PDOWN = 2'b10
   } drc_state_e;

endpackage

// [verilog/drc_sync.sv]
/*
 Two-flop synchroniser for a vector of pins.
 Assumes each bit is independent or held stable around its sampling point.
*/
`timescale 1ns/1ps
module drc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   always_comb
   begin
      meta_nxt = din;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_r <= '0;
         sync_r <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign dout = sync_r;

endmodule

// [verilog/drc_sar.sv]
/*
 Successive-approximation core: one trial bit per clock, MSB first.
 Assumes vin and span/low stay stable from start until done.
*/
`timescale 1ns/1ps
module drc_sar #(
   parameter int unsigned RES = drc_pkg::RES_BITS_DEF
) (
   input  wire logic                             clk_sys,
   input  wire logic                             rstn,
   input  wire logic                             start,
   input  wire logic signed [drc_pkg::VIN_W-1:0] vin,
   input  wire logic signed [drc_pkg::VIN_W-1:0] low,
   input  wire logic        [drc_pkg::SPAN_W-1:0] span,
   output logic                                  done,
   output logic             [RES-1:0]            code
);

   localparam int unsigned IDX_W = $clog2(RES);

   logic             run_r,  run_nxt;
   logic             done_r, done_nxt;
   logic [IDX_W-1:0] idx_r,  idx_nxt;
   logic [RES-1:0]   acc_r,  acc_nxt;
   logic [RES-1:0]   code_r, code_nxt;
   logic [RES-1:0]   trial;
   logic signed [drc_pkg::VIN_W-1:0] diff;
   logic signed [41:0] lhs;
   logic signed [41:0] rhs;

   always_comb
   begin
      trial    = acc_r | (RES'(1) << idx_r);
      diff     = vin - low;
      // Width and LSB from span
      // Compare diff*2^RES against trial*span: no divider needed
      lhs      = 42'(diff) <<< RES;
      rhs      = $signed(42'(trial) * 42'(span));
      run_nxt  = run_r;
      done_nxt = 1'b0;
      idx_nxt  = idx_r;
      acc_nxt  = acc_r;
      code_nxt = code_r;
      if (start)
      begin
         run_nxt = 1'b1;
         idx_nxt = IDX_W'(RES - 1);
         acc_nxt = '0;
      end
      else if (run_r)
      begin
         if (lhs >= rhs)
            acc_nxt = trial;
         if (idx_r == '0)
         begin
            run_nxt  = 1'b0;
            done_nxt = 1'b1;
            code_nxt = {~acc_nxt[RES-1], acc_nxt[RES-2:0]};
         end
         else
            idx_nxt = idx_r - IDX_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         run_r  <= 1'b0;
         done_r <= 1'b0;
         idx_r  <= '0;
         acc_r  <= '0;
         code_r <= '0;
      end
      else
      begin
         run_r  <= run_nxt;
         done_r <= done_nxt;
         idx_r  <= idx_nxt;
         acc_r  <= acc_nxt;
         code_r <= code_nxt;
      end
   end

   assign done = done_r;
   assign code = code_r;

   // Start edge loads, then RES trial edges; done registers on the last trial edge
   localparam int SAR_LAT = RES;

   a_sar_latency: assert property (@(posedge clk_sys) disable iff (!rstn)
      start |=> ##[SAR_LAT:SAR_LAT] done_r)
      else $error("SAR result not ready after RES steps");

endmodule

// [bench/drc_host.sv]
/*
 Host model: drives start, span and channel pins and the analog inputs.
 Assumes busy and tracking come from the control block.
*/
`timescale 1ns/1ps
module drc_host #(
   parameter int unsigned RES = 14
) (
   input  wire logic                 clk_sys,
   input  wire logic                 busy,
   input  wire logic                 tracking,
   output logic                      convert_start_n,
   output logic                      span_sel_lo,
   output logic                      span_sel_hi,
   output logic                      chan_addr,
   output logic signed [25:0]        conv_a_input_one,
   output logic signed [25:0]        conv_a_input_two,
   output logic signed [25:0]        conv_b_input_one,
   output logic signed [25:0]        conv_b_input_two
);
   localparam int UV_A1 = 2500000;
   localparam int UV_A2 = -3000000;
   localparam int UV_B1 = 1000000;
   localparam int UV_B2 = -7500000;
   int   busy_cyc;
   int   timeouts = 0;
   logic hold_trk;

   // Inverted values while held, so a late sample shows up
   task automatic put_inputs(input logic inv);
      conv_a_input_one <= 26'(inv ? -UV_A1 : UV_A1);
      conv_a_input_two <= 26'(inv ? -UV_A2 : UV_A2);
      conv_b_input_one <= 26'(inv ? -UV_B1 : UV_B1);
      conv_b_input_two <= 26'(inv ? -UV_B2 : UV_B2);
   endtask

   initial
   begin
      convert_start_n <= 1'b1;
      span_sel_lo <= 1'b0;
      span_sel_hi <= 1'b0;
      chan_addr <= 1'b0;
      put_inputs(1'b0);
   end

   task automatic pins(input logic [1:0] sp);
      @(posedge clk_sys);
      {span_sel_hi, span_sel_lo} <= sp;
   endtask

   task automatic wake();
      @(posedge clk_sys);
      convert_start_n <= 1'b1;
   endtask

   task automatic convert(input logic ch, input logic [1:0] sp, input logic stay_low);
      int n;
      chan_addr <= ch;
      pins(sp);
      repeat (drc_pkg::ACQ_CYC + 2) @(posedge clk_sys);
      convert_start_n <= 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 10)
      begin
         @(negedge clk_sys);
         n++;
      end
      hold_trk = tracking;
      busy_cyc = 1;
      @(posedge clk_sys);
      put_inputs(1'b1);
      // low at busy fall asks for power-down
      convert_start_n <= !stay_low;
      @(negedge clk_sys);
      while (busy === 1'b1 && busy_cyc < RES + 10)
      begin
         busy_cyc++;
         @(negedge clk_sys);
      end
      if (n >= 10 || busy_cyc >= RES + 10)
         timeouts++;
      @(posedge clk_sys);
      put_inputs(1'b0);
   endtask
endmodule

// [bench/dual_adc_range_channel_control_tb.sv]
/*
 Testbench of the converter range and channel control block.
 Assumes drc_pkg, the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
module dual_adc_range_channel_control_tb;
   localparam int unsigned RES = 14;
   localparam logic [4:0] CHS = 5'b00101;
   localparam logic [9:0] SPS = {2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
   logic               clk_sys;
   logic               rstn;
   logic               reg_wr;
   logic               reg_rd;
   logic [3:0]         reg_addr;
   logic [31:0]        reg_wdata;
   logic [31:0]        reg_rdata;
   logic [31:0]        d;
   logic [31:0]        ea;
   logic [31:0]        eb;
   logic               cs_n, s_lo, s_hi, ch, busy, trk, pdn, flt, prev;
   logic signed [25:0] a1, a2, b1, b2;
   logic [RES-1:0]     ra;
   logic [RES-1:0]     rb;
   logic [1:0]         vs;
   int                 error_cnt = 0;
   int                 total_checks = 0;

   drc_ctrl #(.RES(RES)) dut (.clk_sys(clk_sys), .rstn(rstn), .convert_start_n(cs_n),
      .span_sel_lo(s_lo), .span_sel_hi(s_hi), .chan_addr(ch), .conv_a_input_one(a1),
      .conv_a_input_two(a2), .conv_b_input_one(b1), .conv_b_input_two(b2),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .busy(busy), .tracking(trk), .powered_down(pdn),
      .span_fault(flt), .result_a(ra), .result_b(rb));

   drc_host #(.RES(RES)) host (.clk_sys(clk_sys), .busy(busy), .tracking(trk),
      .convert_start_n(cs_n), .span_sel_lo(s_lo), .span_sel_hi(s_hi), .chan_addr(ch),
      .conv_a_input_one(a1), .conv_a_input_two(a2), .conv_b_input_one(b1),
      .conv_b_input_two(b2));

   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Ideal code, clamped at both ends, MSB flipped to two's complement
   function automatic logic [31:0] exp_code(input longint v, input logic [1:0] sp);
      longint lo, sn, k;
      lo = (sp == 2'h0) ? -10000000 : (sp == 2'h1) ? -5000000 : 0;
      sn = (sp == 2'h0) ? 20000000 : 10000000;
      k = (v < lo) ? 0 : ((v - lo) <<< RES) / sn;
      if (k > (longint'(1) <<< RES) - 1)
         k = (longint'(1) <<< RES) - 1;
      return 32'(k ^ (longint'(1) <<< (RES - 1)));
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      $display("ERROR watchdog expected finish seen hang");
      tally_and_finish();
   end

   initial
   begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd(drc_pkg::REG_STATUS, d);
      chk("status_reset", 32'h00000002, d);
      rd(4'h2, d);
      chk("unmapped", 32'h0, d);
      $display("test reset done");
      prev = 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         if (i == 4)
         begin
            host.wake();
            repeat (4) @(posedge clk_sys);
            chk("pdn_wake", 32'h0, 32'(pdn));
         end
         host.convert(CHS[i], SPS[2*i +: 2], i == 3);
         // Reserved pins keep the last legal span
         if (SPS[2*i +: 2] != 2'h3)
            vs = SPS[2*i +: 2];
         ea = exp_code(prev ? host.UV_A2 : host.UV_A1, vs);
         eb = exp_code(prev ? host.UV_B2 : host.UV_B1, vs);
         chk("result_a", ea, 32'(ra));
         chk("result_b", eb, 32'(rb));
         rd(drc_pkg::REG_RESULT_B, d);
         chk("reg_result_b", eb, d);
         rd(drc_pkg::REG_RESULT_A, d);
         chk("reg_result_a", ea, d);
         chk("busy_len", RES + 2, host.busy_cyc);
         chk("hold", 32'h0, 32'(host.hold_trk));
         chk("track", 32'h1, 32'(trk));
         chk("pdn", 32'(i == 3), 32'(pdn));
         prev = CHS[i];
      end
      $display("test conversions done");
      chk("span_fault", 32'h1, 32'(flt));
      host.pins(2'h1);
      repeat (4) @(posedge clk_sys);
      wr(drc_pkg::REG_CTRL, 32'h1);
      rd(drc_pkg::REG_STATUS, d);
      chk("fault_clr", 32'h10, d & 32'hF0);
      chk("host_timeouts", 32'h0, host.timeouts);
      $display("test span fault done");
      tally_and_finish();
   end
endmodule
